/* File: include/fan_pkg.sv */
// constants, field layouts and carriers for the fan output configuration block
// assumes an index/data port pair driven by the host I/O decoder on the same clock
`default_nettype none

package fan_pkg;

    // register indexes behind the address port
    localparam logic [6:0] IDX_FIRST_PRESCALE = 7'h00;
    localparam logic [6:0] IDX_SECOND_PRESCALE = 7'h02;
    localparam logic [6:0] IDX_SECOND_VALUE = 7'h03;
    localparam logic [6:0] IDX_CONFIG = 7'h04;
    localparam logic [6:0] IDX_FIRST_TARGET = 7'h05;
    localparam logic [6:0] IDX_BANK_SELECT = 7'h4e;

    // reset values and fixed data constants
    localparam logic [7:0] PRESCALE_RESET = 8'h04;
    localparam logic [7:0] TARGET_RESET = 8'h00;
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [7:0] TEMP_TARGET_MASK = 8'h7f;
    localparam logic [7:0] PERIOD_LAST = 8'hff;
    localparam logic [6:0] PRESCALE_ONE = 7'h01;

    // strap sampling: two synchroniser stages then one load edge
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    typedef enum logic [1:0] {
        MODE_MANUAL = 2'b00,
        MODE_TEMP_TRACK = 2'b01,
        MODE_SPEED_TRACK = 2'b10,
        MODE_CURVE = 2'b11
    } control_mode_t;

    localparam logic DRIVE_PWM = 1'b0;
    localparam logic DRIVE_DC = 1'b1;

    // shared configuration register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] reserved;
        control_mode_t second_drive_control_mode;
        control_mode_t first_drive_control_mode;
        logic second_drive_type_select;
        logic first_drive_type_select;
    } fan_cfg_t;

    localparam fan_cfg_t CONFIG_RESET = 8'h01;

    // prescale register layout
    typedef struct packed {
        logic pwm_clock_source_select;
        logic [6:0] pwm_prescale_divider;
    } prescale_t;

    // host side index/data port access
    typedef struct packed {
        logic data_port;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } port_req_t;

endpackage

`default_nettype wire

/* File: logic/fan_output_mode_config.sv */
// fan output configuration, second output value register and two pwm/dc generators
// assumes host port requests and the 24 mhz / 180 khz tick strobes come from logic on clk;
// the strap pin is asynchronous and is synchronised here
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - second output value register, 8 bits read/write, at index 03h.
// - second output value resets from the sampled strap pin, not a constant.
// - pwm duty equals value over 256; ffh drives continuously high.
// - dc level is analog supply times programmed code over 64.
// - config bit 1 picks second drive: 0 pwm (reset), 1 dc.
// - config bit 0 picks first drive: 0 pwm, 1 dc (reset).
// - config bits 5-4 give second control mode; 00 manual after reset.
// - config bits 3-2 give first control mode; 11 reserved, acts as manual.
// - config bits 7-6 reserved, reset and read as zero.
// - index 05h holds 7-bit target temperature in temperature mode, bit 7 reserved.
// - in speed mode all eight bits of 05h are the target speed.
// - pwm frequency is source over prescale divider over 256; zero not programmed.
// - clock source select 0 picks 24 mhz ticks, 1 picks 180 khz.
module fan_output_mode_config #(
    parameter logic [7:0] STRAP_LOW_VALUE = 8'h80,
    parameter logic [7:0] STRAP_HIGH_VALUE = 8'hff,
    parameter int NUM_OUT = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire fan_pkg::port_req_t port_req,
    output logic [7:0] port_rdata,
    input wire logic fan_set_strap,
    input wire logic tick_24m,
    input wire logic tick_180k,
    input wire logic [7:0] first_fan_drive_value,
    output logic [NUM_OUT-1:0] fan_pwm,
    output logic [NUM_OUT-1:0] fan_dc_enable,
    output logic [5:0] first_fan_dc_code,
    output logic [5:0] second_fan_dc_code,
    output fan_pkg::control_mode_t first_drive_control_mode,
    output fan_pkg::control_mode_t second_drive_control_mode,
    output logic [6:0] first_target_temp,
    output logic [7:0] first_target_speed
);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [6:0] index;
    logic [7:0] bank_select;
    logic [7:0] second_fan_drive_value;
    fan_pkg::fan_cfg_t fan_drive_configuration;
    logic [7:0] first_fan_target;
    fan_pkg::prescale_t prescale [NUM_OUT];

    logic strap_meta;
    logic strap_sync;
    logic [1:0] strap_wait;
    logic strap_loaded;

    function automatic logic hit(input logic [6:0] idx, input logic [6:0] want);
        hit = idx == want;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // port decode

    wire index_wr = port_req.wr && !port_req.data_port;
    wire data_wr = port_req.wr && port_req.data_port;
    wire wr_value = data_wr && hit(index, fan_pkg::IDX_SECOND_VALUE);
    wire wr_config = data_wr && hit(index, fan_pkg::IDX_CONFIG);
    wire wr_target = data_wr && hit(index, fan_pkg::IDX_FIRST_TARGET);
    wire wr_bank = data_wr && hit(index, fan_pkg::IDX_BANK_SELECT);
    wire wr_pre0 = data_wr && hit(index, fan_pkg::IDX_FIRST_PRESCALE);
    wire wr_pre1 = data_wr && hit(index, fan_pkg::IDX_SECOND_PRESCALE);

    // reserved config bits never stored
    wire fan_pkg::fan_cfg_t cfg_wdata = {2'b00, port_req.wdata[5:0]};
    // bit 7 reserved while the first output tracks temperature
    wire first_temp_mode =
        fan_drive_configuration.first_drive_control_mode == fan_pkg::MODE_TEMP_TRACK;
    wire [7:0] target_wdata = first_temp_mode
        ? (port_req.wdata & fan_pkg::TEMP_TARGET_MASK)
        : port_req.wdata;

    wire [7:0] data_read =
        hit(index, fan_pkg::IDX_SECOND_VALUE) ? second_fan_drive_value :
        hit(index, fan_pkg::IDX_CONFIG) ? fan_drive_configuration :
        hit(index, fan_pkg::IDX_FIRST_TARGET) ? first_fan_target :
        hit(index, fan_pkg::IDX_FIRST_PRESCALE) ? prescale[0] :
        hit(index, fan_pkg::IDX_SECOND_PRESCALE) ? prescale[1] :
        hit(index, fan_pkg::IDX_BANK_SELECT) ? bank_select :
        fan_pkg::READ_ZERO;
    wire [7:0] next_rdata = port_req.data_port ? data_read : {1'b0, index};

    wire [7:0] strap_value = strap_sync ? STRAP_HIGH_VALUE : STRAP_LOW_VALUE;
    wire strap_take = !strap_loaded && strap_wait == fan_pkg::STRAP_SETTLE;

    // effective first mode: reserved code has no function
    wire fan_pkg::control_mode_t first_mode_eff =
        (fan_drive_configuration.first_drive_control_mode == fan_pkg::MODE_CURVE)
        ? fan_pkg::MODE_MANUAL
        : fan_drive_configuration.first_drive_control_mode;

    ////////////////////////////////////////////////////////////////////////////
    // host port

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            index <= 7'h00;
            port_rdata <= fan_pkg::READ_ZERO;
        end else begin
            if (index_wr) begin
                index <= port_req.wdata[6:0];
            end
            if (port_req.rd) begin
                port_rdata <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap capture

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
            strap_wait <= 2'h0;
            strap_loaded <= 1'b0;
        end else begin
            strap_meta <= fan_set_strap;
            strap_sync <= strap_meta;
            if (!strap_loaded && strap_wait != fan_pkg::STRAP_SETTLE) begin
                strap_wait <= strap_wait + 2'h1;
            end
            if (strap_take) begin
                strap_loaded <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration and value registers

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            second_fan_drive_value <= fan_pkg::READ_ZERO;
            fan_drive_configuration <= fan_pkg::CONFIG_RESET;
            first_fan_target <= fan_pkg::TARGET_RESET;
            bank_select <= fan_pkg::BANK_RESET;
            prescale[0] <= fan_pkg::PRESCALE_RESET;
            prescale[1] <= fan_pkg::PRESCALE_RESET;
        end else begin
            if (wr_value) begin
                second_fan_drive_value <= port_req.wdata;
            end else if (strap_take) begin
                second_fan_drive_value <= strap_value;
            end
            if (wr_config) begin
                fan_drive_configuration <= cfg_wdata;
            end
            if (wr_target) begin
                first_fan_target <= target_wdata;
            end
            if (wr_bank) begin
                bank_select <= port_req.wdata;
            end
            if (wr_pre0) begin
                prescale[0] <= port_req.wdata;
            end
            if (wr_pre1) begin
                prescale[1] <= port_req.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control outputs for the regulation engine

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_drive_control_mode <= fan_pkg::MODE_MANUAL;
            second_drive_control_mode <= fan_pkg::MODE_MANUAL;
            first_target_temp <= 7'h00;
            first_target_speed <= fan_pkg::TARGET_RESET;
        end else begin
            first_drive_control_mode <= first_mode_eff;
            second_drive_control_mode <=
                fan_drive_configuration.second_drive_control_mode;
            first_target_temp <= first_fan_target[6:0];
            first_target_speed <= first_fan_target;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output generators

    wire [7:0] drive_value [NUM_OUT];
    wire drive_sel [NUM_OUT];
    assign drive_value[0] = first_fan_drive_value;
    assign drive_value[1] = second_fan_drive_value;
    assign drive_sel[0] = fan_drive_configuration.first_drive_type_select;
    assign drive_sel[1] = fan_drive_configuration.second_drive_type_select;

    logic [5:0] dc_code [NUM_OUT];

    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g = g + 1) begin : gen_out
            logic [6:0] pre_count;
            logic [7:0] period_count;
            // source tick picked by the select bit
            wire src_tick = prescale[g].pwm_clock_source_select
                ? tick_180k : tick_24m;
            // divider of zero treated as one so the output still runs
            wire [6:0] div_last = (prescale[g].pwm_prescale_divider == 7'h00)
                ? 7'h00 : prescale[g].pwm_prescale_divider - fan_pkg::PRESCALE_ONE;
            wire step = src_tick && pre_count >= div_last;
            wire pwm_level = drive_value[g] == fan_pkg::DUTY_FULL
                || period_count < drive_value[g];

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pre_count <= 7'h00;
                    period_count <= 8'h00;
                    fan_pwm[g] <= 1'b0;
                    fan_dc_enable[g] <= 1'b0;
                    dc_code[g] <= 6'h00;
                end else begin
                    if (step) begin
                        pre_count <= 7'h00;
                        period_count <= period_count + 8'h01;
                    end else if (src_tick) begin
                        pre_count <= pre_count + 7'h01;
                    end
                    fan_pwm[g] <= (drive_sel[g] == fan_pkg::DRIVE_PWM) && pwm_level;
                    fan_dc_enable[g] <= drive_sel[g] == fan_pkg::DRIVE_DC;
                    // dac code, level = supply * code / 64
                    dc_code[g] <= drive_value[g][7:2];
                end
            end
        end
    endgenerate

    assign first_fan_dc_code = dc_code[0];
    assign second_fan_dc_code = dc_code[1];

endmodule // fan_output_mode_config

`default_nettype wire

/* File: bench/fan_output_mode_config_chk.sv */
// port-level assertions for the fan output configuration block
// assumes the host port and fan pins share clk; bound to every instance
`timescale 1ns/1ns
`default_nettype none

module fan_output_mode_config_chk #(
    parameter int NUM_OUT = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire fan_pkg::port_req_t port_req,
    input wire logic [7:0] port_rdata,
    input wire logic [NUM_OUT-1:0] fan_pwm,
    input wire logic [NUM_OUT-1:0] fan_dc_enable,
    input wire logic [5:0] second_fan_dc_code,
    input wire fan_pkg::control_mode_t first_drive_control_mode,
    input wire logic [6:0] first_target_temp,
    input wire logic [7:0] first_target_speed
);
    logic [6:0] idx;
    logic [7:0] v2;
    logic v2_ok;
    logic c1;
    logic [1:0] age;
    wire wr_data = port_req.wr && port_req.data_port;
    wire rd_data = port_req.rd && port_req.data_port;
    wire [1:0] next_age = wr_data ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);

    // shadow of index, second value and drive type as written by the host
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx <= 7'h00;
            v2 <= 8'h00;
            v2_ok <= 1'b0;
            c1 <= 1'b0;
            age <= 2'h0;
        end else begin
            if (port_req.wr && !port_req.data_port) idx <= port_req.wdata[6:0];
            if (wr_data && idx == fan_pkg::IDX_SECOND_VALUE) v2 <= port_req.wdata;
            if (wr_data && idx == fan_pkg::IDX_SECOND_VALUE) v2_ok <= 1'b1;
            if (wr_data && idx == fan_pkg::IDX_CONFIG) c1 <= port_req.wdata[1];
            age <= next_age;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////
    property p_full;
        v2_ok && !c1 && age == 2'h3 && v2 == 8'hff |-> fan_pwm[1];
    endproperty
    a_full: assert property (p_full) else $error("full duty not high");
    property p_zero;
        v2_ok && !c1 && age == 2'h3 && v2 == 8'h00 |-> !fan_pwm[1];
    endproperty
    a_zero: assert property (p_zero) else $error("zero duty not low");
    property p_dc2_low;
        fan_dc_enable[1] |-> !fan_pwm[1];
    endproperty
    a_dc2_low: assert property (p_dc2_low) else $error("second pwm in dc");
    property p_dc1_low;
        fan_dc_enable[0] |-> !fan_pwm[0];
    endproperty
    a_dc1_low: assert property (p_dc1_low) else $error("first pwm in dc");
    property p_dc_code;
        v2_ok && c1 && age == 2'h3 |-> second_fan_dc_code == v2[7:2];
    endproperty
    a_dc_code: assert property (p_dc_code) else $error("dc code wrong");
    property p_cfg_rsv;
        rd_data && idx == fan_pkg::IDX_CONFIG |=> port_rdata[7:6] == 2'b00;
    endproperty
    a_cfg_rsv: assert property (p_cfg_rsv) else $error("reserved bits set");
    property p_mode1;
        first_drive_control_mode != fan_pkg::MODE_CURVE;
    endproperty
    a_mode1: assert property (p_mode1) else $error("first mode 11 acted");
    property p_target;
        first_target_speed[6:0] == first_target_temp;
    endproperty
    a_target: assert property (p_target) else $error("target views differ");
    property p_hold;
        !port_req.rd |=> $stable(port_rdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule // fan_output_mode_config_chk

bind fan_output_mode_config fan_output_mode_config_chk #(.NUM_OUT(NUM_OUT)) i_chk (
    .clk(clk),
    .rst_n(rst_n),
    .port_req(port_req),
    .port_rdata(port_rdata),
    .fan_pwm(fan_pwm),
    .fan_dc_enable(fan_dc_enable),
    .second_fan_dc_code(second_fan_dc_code),
    .first_drive_control_mode(first_drive_control_mode),
    .first_target_temp(first_target_temp),
    .first_target_speed(first_target_speed)
);

`default_nettype wire

/* File: bench/fan_load_model.sv */
// fan load model: senses the pwm pin and reports high cycles per 256 clocks
// assumes the pwm pin is synchronous to clk
`timescale 1ns/1ns
`default_nettype none

module fan_load_model (
    input wire logic clk,
    input wire logic pwm,
    output logic [8:0] duty
);
    logic [7:0] t = 8'h00;
    logic [8:0] acc = 9'h000;
    initial duty = 9'h000;
    // any 256-cycle window of a 256-step period holds the same high count
    always @(posedge clk) begin
        t <= t + 8'h01;
        acc <= (t == 8'hff) ? 9'h000 : acc + {8'h00, pwm};
        if (t == 8'hff) duty <= acc + {8'h00, pwm};
    end
endmodule // fan_load_model

`default_nettype wire

/* File: bench/fan_output_mode_config_bench.sv */
// self-checking bench for the fan output configuration block
// assumes the checker is bound through its own file
`timescale 1ns/1ns
`default_nettype none

module fan_output_mode_config_bench;
    localparam logic [7:0] STRAP_HI = 8'hc4;
    localparam logic [7:0] STRAP_LO = 8'h3a;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    fan_pkg::port_req_t port_req = '0;
    logic tick_24m = 1'b1;
    logic tick_180k = 1'b0;
    logic fan_set_strap = 1'b1;
    logic [7:0] first_fan_drive_value = 8'h00;
    logic [7:0] port_rdata, v, u;
    logic [1:0] fan_pwm, fan_dc_enable;
    logic [5:0] dc1, dc2;
    fan_pkg::control_mode_t m1, m2;
    logic [6:0] ttemp;
    logic [7:0] tspeed;
    logic [8:0] duty;
    logic [7:0] duties [5] = '{8'h00, 8'h02, 8'h80, 8'hfe, 8'hff};
    logic [7:0] exp_q [$];
    logic rd_d = 1'b0;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 32'h1237;

    always #20 clk = ~clk;

    fan_output_mode_config #(.STRAP_LOW_VALUE(STRAP_LO), .STRAP_HIGH_VALUE(STRAP_HI)) i_dut (
        .clk(clk),
        .rst_n(rst_n),
        .port_req(port_req),
        .port_rdata(port_rdata),
        .fan_set_strap(fan_set_strap),
        .tick_24m(tick_24m),
        .tick_180k(tick_180k),
        .first_fan_drive_value(first_fan_drive_value),
        .fan_pwm(fan_pwm),
        .fan_dc_enable(fan_dc_enable),
        .first_fan_dc_code(dc1),
        .second_fan_dc_code(dc2),
        .first_drive_control_mode(m1),
        .second_drive_control_mode(m2),
        .first_target_temp(ttemp),
        .first_target_speed(tspeed)
    );

    fan_load_model i_fan (
        .clk(clk),
        .pwm(fan_pwm[1]),
        .duty(duty)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic op(input logic dp, input logic w, input logic r, input logic [7:0] d);
        @(posedge clk);
        port_req <= '{dp, w, r, d};
    endtask

    task automatic wreg(input logic [6:0] i, input logic [7:0] d);
        op(1'b0, 1'b1, 1'b0, {1'b0, i});
        op(1'b1, 1'b1, 1'b0, d);
        op(1'b0, 1'b0, 1'b0, 8'h00);
    endtask

    task automatic rreg(input logic [6:0] i, input logic [7:0] e);
        exp_q.push_back(e);
        op(1'b0, 1'b1, 1'b0, {1'b0, i});
        op(1'b1, 1'b0, 1'b1, 8'h00);
        op(1'b0, 1'b0, 1'b0, 8'h00);
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // read data monitor and run limit
    always @(posedge clk) begin
        cycles++;
        if (rd_d) chk(port_rdata, exp_q.pop_front(), "rdata");
        rd_d <= port_req.rd;
        if (cycles > 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(fan_dc_enable, 2'b01, "dc_enable");
        rreg(fan_pkg::IDX_FIRST_PRESCALE, 8'h04);
        rreg(fan_pkg::IDX_SECOND_PRESCALE, 8'h04);
        rreg(fan_pkg::IDX_SECOND_VALUE, STRAP_HI);
        rreg(fan_pkg::IDX_CONFIG, 8'h01);
        rreg(fan_pkg::IDX_FIRST_TARGET, 8'h00);
        rreg(7'h01, 8'h00);
        for (int m = 0; m < 4; m++) begin
            wreg(fan_pkg::IDX_CONFIG, {2'b11, m[1:0], m[1:0], 2'b10});
            rreg(fan_pkg::IDX_CONFIG, {2'b00, m[1:0], m[1:0], 2'b10});
            chk(m2, m[1:0], "mode2");
            chk(m1, (m == 3) ? 2'b00 : m[1:0], "mode1");
            chk(fan_dc_enable, 2'b10, "dc_enable");
        end
        wreg(fan_pkg::IDX_CONFIG, 8'h08);
        wreg(fan_pkg::IDX_FIRST_TARGET, 8'ha5);
        rreg(fan_pkg::IDX_FIRST_TARGET, 8'ha5);
        chk(tspeed, 8'ha5, "speed");
        chk(ttemp, 7'h25, "temp");
        wreg(fan_pkg::IDX_CONFIG, 8'h04);
        wreg(fan_pkg::IDX_FIRST_TARGET, 8'hff);
        rreg(fan_pkg::IDX_FIRST_TARGET, 8'h7f);
        wreg(fan_pkg::IDX_CONFIG, 8'h03);
        repeat (6) begin
            v = 8'($random(seed));
            u = ~v;
            first_fan_drive_value <= u;
            wreg(fan_pkg::IDX_SECOND_VALUE, v);
            rreg(fan_pkg::IDX_SECOND_VALUE, v);
            chk(dc2, v[7:2], "dc2");
            chk(dc1, u[7:2], "dc1");
            chk(fan_pwm, 2'b00, "pwm");
        end
        wreg(fan_pkg::IDX_CONFIG, 8'h00);
        wreg(fan_pkg::IDX_SECOND_PRESCALE, 8'h01);
        foreach (duties[k]) begin
            wreg(fan_pkg::IDX_SECOND_VALUE, duties[k]);
            repeat (600) @(posedge clk);
            chk(duty, duties[k] == 8'hff ? 9'h100 : {1'b0, duties[k]}, "duty");
        end
        // second output on the slow source only; fast source stopped
        tick_24m <= 1'b0;
        tick_180k <= 1'b1;
        wreg(fan_pkg::IDX_SECOND_PRESCALE, 8'h81);
        wreg(fan_pkg::IDX_SECOND_VALUE, 8'h40);
        repeat (600) @(posedge clk);
        chk(duty, 9'h040, "duty_180k");
        // mid-run reset with the strap low
        fan_set_strap <= 1'b0;
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk(fan_dc_enable, 2'b01, "dc_enable_rst");
        rreg(fan_pkg::IDX_SECOND_VALUE, STRAP_LO);
        rreg(fan_pkg::IDX_CONFIG, 8'h01);
        repeat (2) @(posedge clk);
        end_of_test();
    end
endmodule // fan_output_mode_config_bench

`default_nettype wire
